// *** verilog/timer_pkg.sv ***
package timer_pkg;

  localparam int          CNT_W        = 10;
  localparam int          BANK_BIT     = 6;
  localparam int          MAP_TOP_BIT  = 7;
  localparam logic [5:0]  OFF_CTRL0    = 6'h00;
  localparam logic [5:0]  OFF_CTRL1    = 6'h04;
  localparam logic [5:0]  OFF_CNT_LO   = 6'h08;
  localparam logic [5:0]  OFF_CNT_HI   = 6'h0C;
  localparam logic [5:0]  OFF_CMPA_LO  = 6'h10;
  localparam logic [5:0]  OFF_CMPA_HI  = 6'h14;
  localparam logic [5:0]  OFF_CMPP_LO  = 6'h18;
  localparam logic [5:0]  OFF_CMPP_HI  = 6'h1C;
  localparam logic [5:0]  OFF_CAPSRC   = 6'h20;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [9:0]  CNT_RST      = 10'h000;
  localparam logic [9:0]  CNT_TOP      = 10'h3FF;
  localparam logic [9:0]  CNT_ONE      = 10'h001;
  localparam logic [6:0]  P_LSB_ZERO   = 7'h00;
  localparam logic [5:0]  PRE_RST      = 6'h00;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  // Output pin function codes, meaning depends on mode
  localparam logic [1:0]  IO_NONE      = 2'b00;
  localparam logic [1:0]  IO_LOW       = 2'b01;
  localparam logic [1:0]  IO_HIGH      = 2'b10;
  localparam logic [1:0]  IO_TOGGLE    = 2'b11;
  localparam logic [1:0]  IO_INACTIVE  = 2'b00;
  localparam logic [1:0]  IO_ACTIVE    = 2'b01;
  localparam logic [1:0]  IO_PWM       = 2'b10;
  localparam logic [1:0]  IO_SPULSE    = 2'b11;
  localparam logic [1:0]  CAP_RISE     = 2'b00;
  localparam logic [1:0]  CAP_FALL     = 2'b01;
  localparam logic [1:0]  CAP_BOTH     = 2'b10;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00, MODE_CAP = 2'b01, MODE_PWM = 2'b10, MODE_CNT = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    CK_SYS4 = 3'b000, CK_SYS = 3'b001, CK_H16 = 3'b010, CK_H64 = 3'b011,
    CK_SUB0 = 3'b100, CK_SUB1 = 3'b101, CK_EXT_R = 3'b110, CK_EXT_F = 3'b111
  } clk_sel_t;

  typedef struct packed {
    logic       pause;
    clk_sel_t   clock_select_field;
    logic       timer_on_bit;
    logic [2:0] period_code;
  } timer_control_zero_t;

  typedef struct packed {
    mode_t      mode;
    logic [1:0] pin_function_field;
    logic       out_init;
    logic       out_pol;
    logic       duty_swap;
    logic       clear_on_a;
  } timer_control_one_t;

  typedef struct packed {
    logic cap;
    logic clk;
  } timer_pins_t;

endpackage : timer_pkg

// *** verilog/timer_pair.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Two timers: standard (index 0) and periodic (index 1), same common logic.
// - Count-up counter; compare match raises interrupt, may clear counter, change pin.
// - Three-bit clock select picks system ratio, high clock, sub clock or pin.
// - Separate interrupt pulses for comparator A match and comparator P match.
// - External clock pin counts on rising or falling edge per clock select.
// - In single pulse mode the external clock pin edge triggers the pulse.
// - Capture pin edge: rising, falling or both, from the pin function field.
// - Periodic timer may capture from its external clock pin instead.
// - Compare output mode: pin goes high, low or toggles on A match.
// - Inverted pin always equals the inverse of the periodic output pin.
// - PWM waveform appears on the output pin and its inverted twin.
// - Edge aligned PWM; duty or period is adjustable, selected by a bit.
// - Counter and compare registers split in bytes; low bytes through shared buffer.
// - Compare low byte write only loads the holding buffer.
// - Compare high byte write stores high byte and copies buffer into low.
// - High byte read returns high byte and latches live low byte into buffer.
// - Low byte read returns the holding buffer, not the live low byte.
// - Counters are ten bits wide and count upward.
// - Counter clears on timer on rising edge, on overflow, on selected match.
module timer_pair
  import timer_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        I_MCLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_CE,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Timer pins and sub clock
  input  wire logic        I_FSUB,
  input  wire timer_pins_t I_STD_PINS,
  input  wire timer_pins_t I_PER_PINS,
  output logic             O_STD_OUT,
  output logic             O_PER_OUT,
  output logic             O_PER_OUT_N,
  // Interrupt source pulses, index 0 standard, 1 periodic
  output logic      [1:0]  O_IRQ_A,
  output logic      [1:0]  O_IRQ_P
);

  timer_control_zero_t c0_q [2];
  timer_control_one_t  c1_q [2];
  logic [9:0]  cnt_q [2];
  logic [9:0]  cmpa_q [2];
  logic [7:0]  buf_q [2];
  logic [9:0]  cmpp_q;
  logic        capsrc_q;
  logic [1:0]  on_prev_q, pulse_q, out_q;
  logic        out_n_q;
  logic [1:0]  irq_a_q, irq_p_q;
  logic [5:0]  pre_q;
  logic [4:0]  s1_q, s2_q, s3_q;
  logic [4:0]  rise, fall;
  logic        ready_q, ok_q;
  logic [31:0] rdata_q;
  logic [9:0]  pval [2];
  logic [9:0]  plast [2];
  logic [9:0]  duty [2];
  logic [1:0]  on_rise, trig, tick, a_hit, p_hit, cap_ev, out_d;
  logic        src_r, src_f;
  logic        bk, mapped, setup, acc, wr, rd;
  logic [5:0]  off;
  logic [31:0] rd_word;

  function automatic logic sel_tick(clk_sel_t s, logic [5:0] pre, logic sub, logic er, logic ef);
    logic t;
    t = 1'b0;
    unique case (s)
      CK_SYS4:          t = &pre[1:0];
      CK_SYS:           t = 1'b1;
      CK_H16:           t = &pre[3:0];
      CK_H64:           t = &pre;
      CK_SUB0, CK_SUB1: t = sub;
      CK_EXT_R:         t = er;
      CK_EXT_F:         t = ef;
    endcase
    return t;
  endfunction : sel_tick

  function automatic logic [9:0] last_count(logic [9:0] v);
    return (v == CNT_RST) ? CNT_TOP : v - CNT_ONE;
  endfunction : last_count

  function automatic logic reg_ok(logic [7:0] a);
    logic [5:0] o;
    logic       per;
    o   = a[5:0];
    per = a[BANK_BIT];
    if (a[MAP_TOP_BIT])
      return 1'b0;
    if (o == OFF_CTRL0 || o == OFF_CTRL1 || o == OFF_CNT_LO || o == OFF_CNT_HI ||
        o == OFF_CMPA_LO || o == OFF_CMPA_HI)
      return 1'b1;
    return per && (o == OFF_CMPP_LO || o == OFF_CMPP_HI || o == OFF_CAPSRC);
  endfunction : reg_ok

  // Pin synchronisers: bit 0 sub clock, 1/2 standard clk/cap, 3/4 periodic clk/cap
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end else if (I_CE) begin
      s1_q <= {I_PER_PINS.cap, I_PER_PINS.clk, I_STD_PINS.cap, I_STD_PINS.clk, I_FSUB};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN)
      pre_q <= PRE_RST;
    else if (I_CE)
      pre_q <= pre_q + 6'h01;
  end

  always_comb begin
    src_r = 1'b0;
    src_f = 1'b0;
    for (int i = 0; i < 2; i++) begin
      pval[i]    = (i == 0) ? {c0_q[0].period_code, P_LSB_ZERO} : cmpp_q;
      plast[i]   = last_count(pval[i]);
      duty[i]    = c1_q[i].duty_swap ? pval[i] : cmpa_q[i];
      on_rise[i] = c0_q[i].timer_on_bit & ~on_prev_q[i];
      trig[i]    = rise[1 + 2 * i] & c0_q[i].timer_on_bit & (c1_q[i].mode == MODE_PWM) &
                   (c1_q[i].pin_function_field == IO_SPULSE);
      tick[i]    = c0_q[i].timer_on_bit & ~c0_q[i].pause & ~trig[i] &
                   sel_tick(c0_q[i].clock_select_field, pre_q, rise[0],
                            rise[1 + 2 * i], fall[1 + 2 * i]) &
                   (~trig[i] & (pulse_q[i] | ~((c1_q[i].mode == MODE_PWM) &
                   (c1_q[i].pin_function_field == IO_SPULSE))));
      a_hit[i]   = tick[i] & (cnt_q[i] == cmpa_q[i]);
      p_hit[i]   = tick[i] & (cnt_q[i] == plast[i]);
      if (i == 1 && capsrc_q) begin
        src_r = rise[3];
        src_f = fall[3];
      end else begin
        src_r = rise[2 + 2 * i];
        src_f = fall[2 + 2 * i];
      end
      cap_ev[i] = 1'b0;
      if (c0_q[i].timer_on_bit && c1_q[i].mode == MODE_CAP) begin
        case (c1_q[i].pin_function_field)
          CAP_RISE: cap_ev[i] = src_r;
          CAP_FALL: cap_ev[i] = src_f;
          CAP_BOTH: cap_ev[i] = src_r | src_f;
          default:  cap_ev[i] = 1'b0;
        endcase
      end
      out_d[i] = out_q[i];
      case (c1_q[i].mode)
        MODE_CMP: begin
          if (a_hit[i]) begin
            case (c1_q[i].pin_function_field)
              IO_LOW:    out_d[i] = 1'b0;
              IO_HIGH:   out_d[i] = 1'b1;
              IO_TOGGLE: out_d[i] = ~out_q[i];
              default:   out_d[i] = out_q[i];
            endcase
          end
        end
        MODE_PWM: begin
          case (c1_q[i].pin_function_field)
            IO_INACTIVE: out_d[i] = c1_q[i].out_pol;
            IO_ACTIVE:   out_d[i] = ~c1_q[i].out_pol;
            IO_PWM:      out_d[i] = (cnt_q[i] < duty[i]) ^ c1_q[i].out_pol;
            default:     out_d[i] = pulse_q[i] ^ c1_q[i].out_pol;
          endcase
        end
        default: out_d[i] = out_q[i];
      endcase
      if (on_rise[i] && (c1_q[i].mode == MODE_CMP || c1_q[i].mode == MODE_PWM))
        out_d[i] = c1_q[i].out_init;
    end
  end

  // Counters
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 2; i++)
        cnt_q[i] <= CNT_RST;
      on_prev_q <= 2'b00;
    end else if (I_CE) begin
      for (int i = 0; i < 2; i++) begin
        if (on_rise[i] || trig[i])
          cnt_q[i] <= CNT_RST;
        else if (tick[i])
          cnt_q[i] <= (c1_q[i].clear_on_a ? a_hit[i] : p_hit[i]) ? CNT_RST : cnt_q[i] + CNT_ONE;
        on_prev_q[i] <= c0_q[i].timer_on_bit;
      end
    end
  end

  // Single pulse, output pins, interrupt pulses
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pulse_q <= 2'b00;
      out_q   <= 2'b00;
      out_n_q <= 1'b1;
      irq_a_q <= 2'b00;
      irq_p_q <= 2'b00;
    end else if (I_CE) begin
      for (int i = 0; i < 2; i++) begin
        if (!c0_q[i].timer_on_bit || on_rise[i])
          pulse_q[i] <= 1'b0;
        else if (trig[i])
          pulse_q[i] <= 1'b1;
        else if (a_hit[i])
          pulse_q[i] <= 1'b0;
      end
      out_q   <= out_d;
      out_n_q <= ~out_d[1];
      irq_a_q <= a_hit | cap_ev;
      irq_p_q <= p_hit;
    end
  end

  assign O_STD_OUT   = out_q[0];
  assign O_PER_OUT   = out_q[1];
  assign O_PER_OUT_N = out_n_q;
  assign O_IRQ_A     = irq_a_q;
  assign O_IRQ_P     = irq_p_q;

  // APB slave: data latched in setup, ready in the first access cycle
  assign bk     = I_PADDR[BANK_BIT];
  assign off    = I_PADDR[5:0];
  assign mapped = reg_ok(I_PADDR);
  assign setup  = I_PSEL & ~ready_q;
  assign acc    = I_PSEL & I_PENABLE & ready_q;
  assign wr     = acc & I_PWRITE & ok_q;
  assign rd     = setup & ~I_PWRITE & mapped;

  always_comb begin
    rd_word = RDATA_RST;
    case (off)
      OFF_CTRL0:   rd_word[7:0] = c0_q[bk];
      OFF_CTRL1:   rd_word[7:0] = c1_q[bk];
      OFF_CNT_HI:  rd_word[1:0] = cnt_q[bk][9:8];
      OFF_CMPA_HI: rd_word[1:0] = cmpa_q[bk][9:8];
      OFF_CMPP_HI: rd_word[1:0] = cmpp_q[9:8];
      OFF_CAPSRC:  rd_word[0]   = capsrc_q;
      default:     rd_word[7:0] = buf_q[bk];
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ready_q <= 1'b0;
      ok_q    <= 1'b0;
      rdata_q <= RDATA_RST;
    end else if (I_CE) begin
      if (setup) begin
        ready_q <= 1'b1;
        ok_q    <= mapped;
        rdata_q <= rd ? rd_word : RDATA_RST;
      end else if (acc) begin
        ready_q <= 1'b0;
      end
    end
  end

  assign O_PRDATA  = rdata_q;
  assign O_PREADY  = I_PENABLE & ready_q & I_CE;
  assign O_PSLVERR = O_PREADY & ~ok_q;

  // Shared low byte holding buffers
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 2; i++)
        buf_q[i] <= BYTE_RST;
    end else if (I_CE) begin
      if (rd) begin
        case (off)
          OFF_CNT_HI:  buf_q[bk] <= cnt_q[bk][7:0];
          OFF_CMPA_HI: buf_q[bk] <= cmpa_q[bk][7:0];
          OFF_CMPP_HI: buf_q[bk] <= cmpp_q[7:0];
          default:     buf_q[bk] <= buf_q[bk];
        endcase
      end
      if (wr && (off == OFF_CMPA_LO || off == OFF_CMPP_LO))
        buf_q[bk] <= I_PWDATA[7:0];
    end
  end

  // Control and compare registers
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 2; i++) begin
        c0_q[i]   <= CTRL_RST;
        c1_q[i]   <= CTRL_RST;
        cmpa_q[i] <= CNT_RST;
      end
      cmpp_q   <= CNT_RST;
      capsrc_q <= 1'b0;
    end else if (I_CE) begin
      for (int i = 0; i < 2; i++) begin
        if (wr && int'(bk) == i && off == OFF_CTRL0)
          c0_q[i] <= I_PWDATA[7:0];
        if (wr && int'(bk) == i && off == OFF_CTRL1)
          c1_q[i] <= I_PWDATA[7:0];
        if (cap_ev[i])
          cmpa_q[i] <= cnt_q[i];
        else if (wr && int'(bk) == i && off == OFF_CMPA_HI)
          cmpa_q[i] <= {I_PWDATA[1:0], buf_q[i]};
      end
      if (wr && off == OFF_CMPP_HI)
        cmpp_q <= {I_PWDATA[1:0], buf_q[1]};
      if (wr && off == OFF_CAPSRC)
        capsrc_q <= I_PWDATA[0];
    end
  end

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);

  chk_inv_pin: assert property (O_PER_OUT_N == ~O_PER_OUT)
    else $error("inverted pin not inverse of output");
  chk_on_clear: assert property (I_CE && on_rise[0] |=> cnt_q[0] == CNT_RST)
    else $error("counter not cleared on timer on");
  chk_p_clear: assert property (I_CE && p_hit[1] && !c1_q[1].clear_on_a |=> cnt_q[1] == CNT_RST)
    else $error("counter not cleared on P match");
  chk_a_irq: assert property (I_CE && a_hit[0] |=> O_IRQ_A[0] ##1 (!I_CE || !$past(a_hit[0]) || O_IRQ_A[0]))
    else $error("A match interrupt missing");
  chk_lo_write: assert property (I_CE && wr && !bk && off == OFF_CMPA_LO && !cap_ev[0]
                                 |=> cmpa_q[0] == $past(cmpa_q[0]) && buf_q[0] == $past(I_PWDATA[7:0]))
    else $error("low byte write reached compare register");
  chk_hi_write: assert property (I_CE && wr && bk && off == OFF_CMPA_HI && !cap_ev[1]
                                 |=> cmpa_q[1] == {$past(I_PWDATA[1:0]), $past(buf_q[1])})
    else $error("high byte write did not merge buffer");
  chk_hi_read: assert property (I_CE && rd && !bk && off == OFF_CNT_HI
                                |=> buf_q[0] == $past(cnt_q[0][7:0]) && O_PRDATA[1:0] == $past(cnt_q[0][9:8]))
    else $error("high byte read did not latch low byte");
  chk_lo_read: assert property (I_CE && rd && !bk && off == OFF_CMPA_LO |=> O_PRDATA[7:0] == $past(buf_q[0]))
    else $error("low byte read not from buffer");
  chk_cmp_toggle: assert property (I_CE && a_hit[0] && !on_rise[0] && c1_q[0].mode == MODE_CMP &&
                                   c1_q[0].pin_function_field == IO_TOGGLE |=> O_STD_OUT != $past(O_STD_OUT))
    else $error("compare toggle missing");
  chk_capture: assert property (I_CE && cap_ev[1] |=> cmpa_q[1] == $past(cnt_q[1]) && O_IRQ_A[1])
    else $error("capture did not load compare A");

  cov_p_match: cover property (p_hit[1] ##1 O_IRQ_P[1]);
  cov_capture: cover property (cap_ev[1] && capsrc_q);
  cov_pulse:   cover property (!pulse_q[1] ##1 pulse_q[1]);
  cov_pwm:     cover property (c1_q[1].mode == MODE_PWM && O_PER_OUT ##1 !O_PER_OUT);

endmodule : timer_pair

// *** testbench/timer_pin_model.sv ***
`timescale 1ns/1ns
module timer_pin_model
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  // Pins toward the timers
  output timer_pins_t o_std_pins,
  output timer_pins_t o_per_pins,
  output logic        o_fsub
);
  logic [3:0] pins_q;
  logic [2:0] sub_q;

  initial begin
    pins_q = 4'h0;
  end
  assign o_std_pins = pins_q[1:0];
  assign o_per_pins = pins_q[3:2];
  assign o_fsub     = sub_q[2];

  // Sub clock runs free, one rising edge every 8 system cycles
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sub_q <= 3'h0;
    end else begin
      sub_q <= sub_q + 3'h1;
    end
  end

  // Index is {periodic, capture}; level changes 3 cycles after the call
  task automatic set_pin(input logic [1:0] idx, input logic v);
    repeat (3) @(posedge i_clk);
    pins_q[idx] <= v;
  endtask : set_pin

  task automatic ext_pulses(input logic per, input int n);
    repeat (n) begin
      set_pin({per, 1'b0}, 1'b1);
      set_pin({per, 1'b0}, 1'b0);
    end
  endtask : ext_pulses
endmodule : timer_pin_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
  import timer_pkg::*;
;
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, fsub, ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  timer_pins_t std_pins, per_pins;
  logic        std_out, per_out, per_out_n;
  logic [1:0]  irq_a, irq_p;
  logic [3:0]  irqv;
  int          miscompares;
  int          cmp_count;

  assign irqv = {irq_p, irq_a};

  timer_pair DUT (.I_MCLK(mclk), .I_RSTN(rstn), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_FSUB(fsub), .I_STD_PINS(std_pins), .I_PER_PINS(per_pins),
    .O_STD_OUT(std_out), .O_PER_OUT(per_out), .O_PER_OUT_N(per_out_n), .O_IRQ_A(irq_a), .O_IRQ_P(irq_p));

  timer_pin_model pm (.i_clk(mclk), .i_rstn(rstn), .o_std_pins(std_pins), .o_per_pins(per_pins),
    .o_fsub(fsub));

  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tmo(input string name);
    miscompares++;
    $display("Error %s expected done seen timeout", name);
    end_of_test;
  endtask : tmo

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) tmo("pready");
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(a, 1'b0, 32'h0, d, e);
  endtask : rd

  task automatic wait_pulse(input int sel, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (irqv[sel] !== 1'b1 && n < 3000);
    if (irqv[sel] !== 1'b1) tmo("irq");
  endtask : wait_pulse

  task automatic t_reset;
    logic [31:0] d;
    logic        e;
    chk("out_n", per_out_n, 1);
    chk("out", std_out, 0);
    rd(8'h00, d);
    chk("ctrl0", d, 0);
    rd(8'h44, d);
    chk("per ctrl1", d, 0);
    apb(8'h80, 1'b0, 32'h0, d, e);
    chk("unmapped err", e, 1);
    chk("unmapped data", d, 0);
  endtask : t_reset

  task automatic t_bytes;
    logic [31:0] d;
    wr(8'h10, 32'h5A);
    rd(8'h14, d);
    chk("a high", d, 0);
    rd(8'h10, d);
    chk("a low kept", d, 0);
    wr(8'h10, 32'hA5);
    wr(8'h14, 32'h2);
    wr(8'h10, 32'h3C);
    rd(8'h10, d);
    chk("buffer read", d, 32'h3C);
    rd(8'h14, d);
    chk("a high", d, 32'h2);
    rd(8'h10, d);
    chk("a low", d, 32'hA5);
  endtask : t_bytes

  task automatic t_period;
    clk_sel_t   sel [5] = '{CK_SYS, CK_SYS4, CK_H16, CK_H64, CK_SUB0};
    int         dv [5] = '{1, 4, 16, 64, 8};
    logic [1:0] io [3] = '{IO_HIGH, IO_NONE, IO_LOW};
    int         n;
    logic       o1;
    wr(8'h04, 32'h31);
    wr(8'h10, 32'd20);
    wr(8'h14, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, {24'h0, 1'b0, sel[i], 1'b1, 3'b001});
      wait_pulse(0, n);
      repeat (2) @(negedge mclk);
      o1 = std_out;
      wait_pulse(0, n);
      repeat (2) @(negedge mclk);
      chk("a period", n, 21 * dv[i] - 2);
      chk("toggle", std_out, !o1);
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, {24'h0, 2'b00, io[i], 4'h1});
      // A match may land on the write edge under the old setting, so skip one
      wait_pulse(0, n);
      wait_pulse(0, n);
      repeat (2) @(negedge mclk);
      chk("match out", std_out, i < 2);
    end
    wr(8'h04, 32'h30);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h19);
    wait_pulse(2, n);
    wait_pulse(2, n);
    chk("p period", n, 128);
    wait_pulse(0, n);
    chk("a after p", n, 21);
  endtask : t_period

  task automatic t_extclk;
    clk_sel_t    sel [2] = '{CK_EXT_R, CK_EXT_F};
    logic [31:0] hi, lo;
    wr(8'h04, 32'hC0);
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, {24'h0, 1'b0, sel[i], 1'b1, 3'b000});
      pm.ext_pulses(1'b0, 5);
      pm.set_pin(2'd0, 1'b1);
      repeat (6) @(negedge mclk);
      rd(8'h0C, hi);
      rd(8'h08, lo);
      chk("ext count", {hi[1:0], lo[7:0]}, 6 - i);
      wr(8'h00, 32'h0);
      pm.set_pin(2'd0, 1'b0);
    end
  endtask : t_extclk

  task automatic t_pwm;
    int n;
    int hc = 0;
    int bad = 0;
    wr(8'h40, 32'h0);
    wr(8'h44, 32'hA0);
    wr(8'h58, 32'd40);
    wr(8'h5C, 32'h0);
    wr(8'h50, 32'd10);
    wr(8'h54, 32'h0);
    wr(8'h40, 32'h18);
    wait_pulse(3, n);
    repeat (80) begin
      @(negedge mclk);
      hc += per_out;
      bad += (per_out_n !== ~per_out);
    end
    chk("pwm high", hc, 20);
    chk("inverse", bad, 0);
    hc = 0;
    @(posedge mclk);
    ce <= 1'b0;
    @(negedge mclk);
    n = per_out;
    repeat (50) begin
      @(negedge mclk);
      hc += (per_out !== n[0]);
    end
    @(posedge mclk);
    ce <= 1'b1;
    chk("frozen out", hc, 0);
    wr(8'h44, 32'h90);
    repeat (2) @(negedge mclk);
    chk("pwm active", per_out, 1);
  endtask : t_pwm

  task automatic edge_irq(input logic [1:0] idx, input logic v, output int c);
    pm.set_pin(idx, v);
    c = 0;
    repeat (12) begin
      @(negedge mclk);
      c += irq_a[1];
    end
  endtask : edge_irq

  task automatic t_capture;
    int c;
    for (int i = 0; i < 3; i++) begin
      wr(8'h40, 32'h0);
      wr(8'h60, 32'h0);
      wr(8'h44, {24'h0, 2'b01, i[1:0], 4'h0});
      // Paused counter: no compare A match can mimic a capture pulse
      wr(8'h40, 32'h98);
      edge_irq(2'd3, 1'b1, c);
      chk("cap rise", c, i != 1);
      edge_irq(2'd3, 1'b0, c);
      chk("cap fall", c, i != 0);
    end
    wr(8'h40, 32'h0);
    wr(8'h60, 32'h1);
    wr(8'h44, 32'h40);
    wr(8'h40, 32'h98);
    edge_irq(2'd2, 1'b1, c);
    chk("cap ext", c, 1);
    edge_irq(2'd2, 1'b0, c);
  endtask : t_capture

  task automatic t_pulse;
    int n = 0;
    int hc = 0;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hB0);
    wr(8'h10, 32'd10);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h18);
    chk("pulse idle", std_out, 0);
    pm.set_pin(2'd0, 1'b1);
    while (std_out !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    while (std_out === 1'b1 && hc < 50) begin
      @(negedge mclk);
      hc++;
    end
    chk("pulse width", hc inside {[11:12]}, 1);
    pm.set_pin(2'd0, 1'b0);
  endtask : t_pulse

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ce = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_bytes;
    t_period;
    t_extclk;
    t_pwm;
    t_capture;
    t_pulse;
    end_of_test;
  end
endmodule : tb_top
